/* hdl/tmcf_pkg.sv */
/*
 Package for the timer compare-output and flag block:
 register indexes, field positions, reset values, types.
 Assumes a single 10 MHz clock domain.
*/
`default_nettype none
package tmcf_pkg;
   localparam int        ADDR_W        = 3;
   localparam int        DATA_W        = 8;
   // Register addresses
   localparam logic [2:0] ADDR_CH0_SC  = 3'h0;
   localparam logic [2:0] ADDR_CH1_SC  = 3'h1;
   localparam logic [2:0] ADDR_IRQ_ST  = 3'h2;
   localparam logic [2:0] ADDR_IRQ_MSK = 3'h3;
   // Field positions in the status/control registers
   localparam int        BIT_MFB       = 7;
   localparam int        BIT_MFA       = 6;
   localparam int        BIT_OVF       = 5;
   localparam int        BIT_B4        = 4;
   localparam int        OSB_HI        = 3;
   localparam int        OSA_HI        = 1;
   // Reset values
   localparam logic [7:0] CH0_RST      = 8'h00;
   localparam logic [7:0] CH1_RST      = 8'h10;
   localparam logic [7:0] ZERO8        = 8'h00;
   localparam logic [5:0] ZERO6        = 6'h00;
   // Output select codes
   localparam logic [1:0] OS_KEEP      = 2'h0;
   localparam logic [1:0] OS_LOW       = 2'h1;
   localparam logic [1:0] OS_HIGH      = 2'h2;
   localparam logic [1:0] OS_TOGGLE    = 2'h3;
   localparam logic [7:0] CNT_MAX      = 8'hFF;

   typedef struct packed {
      logic [7:0] count;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic       tick;
      logic       xfer_a;
      logic       xfer_b;
   } tmcf_chan_in_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } tmcf_bus_type;
endpackage
`default_nettype wire

/* hdl/tmcf_top.sv */
/*
 Compare-match output control and flags for two 8-bit timer channels.
 Assumes counters live outside; each supplies its count, compare values,
 a one-cycle count tick, and transfer-controller clear requests.
*/
// Function
// - Match B: B select 00 keep, 01 low, 10 high, 11 toggle.
// - Match A: A select 00 keep, 01 low, 10 high, 11 toggle.
// - Output function disabled while all four select bits are zero.
// - Output pin is low after reset until first compare match.
// - Bit 7 flag sets when count equals compare value B.
// - Bit 6 flag sets when count equals compare value A.
// - Overflow flag sets when counter wraps from maximum to zero.
// - Flags only take written zero, clearing only after read as one.
// - Overflow flag clears on zero write after reading it as one.
// - Transfer started by match B request, disable-select 0, clears B.
// - Transfer started by match A request, disable-select 0, clears A.
// - Channel 1 bit 4 reserved: reads one, writes ignored.
// - Match issues in last equal state, acting at next count tick.
`default_nettype none
module tmcf_top (
   input  wire logic                     mclk,
   input  wire logic                     sys_rst,
   input  wire tmcf_pkg::tmcf_bus_type   bus,
   output logic [tmcf_pkg::DATA_W-1:0]   rdata,
   input  wire tmcf_pkg::tmcf_chan_in_type ch0,
   input  wire tmcf_pkg::tmcf_chan_in_type ch1,
   output logic [1:0]                    timer_output_pin,
   output logic [1:0]                    timer_output_en,
   output logic                          irq
);
   import tmcf_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   function automatic logic sel(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] r);
      sel = (a == r);
   endfunction

   // Pin level after one match under a 2-bit output select
   function automatic logic os_act(input logic       hit,
                                   input logic [1:0] os,
                                   input logic       cur,
                                   input logic       base);
      os_act = cur;
      if (hit) begin
         case (os)
            OS_LOW:    os_act = 1'b0;
            OS_HIGH:   os_act = 1'b1;
            OS_TOGGLE: os_act = ~base;
            default:   os_act = cur;
         endcase
      end
   endfunction

   wire logic [1:0] wr_sc = {bus.wr & sel(bus.addr, ADDR_CH1_SC),
                             bus.wr & sel(bus.addr, ADDR_CH0_SC)};
   wire logic [1:0] rd_sc = {bus.rd & sel(bus.addr, ADDR_CH1_SC),
                             bus.rd & sel(bus.addr, ADDR_CH0_SC)};
   wire logic wr_st  = bus.wr & sel(bus.addr, ADDR_IRQ_ST);
   wire logic wr_msk = bus.wr & sel(bus.addr, ADDR_IRQ_MSK);

   tmcf_chan_in_type chn [2];
   assign chn[0] = ch0;
   assign chn[1] = ch1;

   logic [7:0] sc_ff       [2];
   logic [2:0] seen_ff     [2];
   logic [5:0] ev_ff;
   logic [5:0] msk_ff;
   logic [5:0] ev_set;
   logic [7:0] rdata_ff;
   logic [7:0] sc_view     [2];

   ////////////////////////////////////////////////////////////////////
   // Per-channel flags and output
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gch
         logic       pin_ff;
         logic       pin_b;
         logic       nxt_pin;
         logic [7:0] nxt_sc;
         logic [2:0] nxt_seen;
         logic [2:0] set_f;
         logic [2:0] sw_clr;
         logic [2:0] hw_clr;
         wire logic  eq_a = chn[g].tick & (chn[g].count == chn[g].cmp_a);
         wire logic  eq_b = chn[g].tick & (chn[g].count == chn[g].cmp_b);
         wire logic  wrap = chn[g].tick & (chn[g].count == CNT_MAX);
         wire logic [1:0] os_a = sc_ff[g][OSA_HI -: 2];
         wire logic [1:0] os_b = sc_ff[g][OSB_HI -: 2];

         // Match taken on the tick, in the last equal state
         assign set_f = {eq_b, eq_a, wrap};
         assign hw_clr = {chn[g].xfer_b, chn[g].xfer_a, 1'b0};
         // Zero written to a flag seen as one clears it
         assign sw_clr = {3{wr_sc[g]}} & ~bus.wdata[BIT_MFB:BIT_OVF]
                         & seen_ff[g];

         // Match B first, match A prevails in a shared cycle
         assign pin_b   = os_act(eq_b, os_b, pin_ff, pin_ff);
         assign nxt_pin = os_act(eq_a, os_a, pin_b, pin_ff);

         always_comb begin
            nxt_sc = sc_ff[g];
            if (wr_sc[g]) begin
               nxt_sc[OSB_HI:0] = bus.wdata[OSB_HI:0];
               if (g == 0) begin
                  nxt_sc[BIT_B4] = bus.wdata[BIT_B4];
               end
            end
            nxt_sc[BIT_MFB:BIT_OVF] = (sc_ff[g][BIT_MFB:BIT_OVF]
                                       & ~(sw_clr | hw_clr))
                                      | set_f;
            if (g == 1) begin
               nxt_sc[BIT_B4] = 1'b1;
            end
         end

         // Flags read as one arm the zero-write clear
         always_comb begin
            nxt_seen = seen_ff[g];
            if (rd_sc[g]) begin
               nxt_seen = sc_ff[g][BIT_MFB:BIT_OVF];
            end
            if (wr_sc[g]) begin
               nxt_seen = 3'h0;
            end
         end

         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               pin_ff     <= 1'b0;
               sc_ff[g]   <= (g == 1) ? CH1_RST : CH0_RST;
               seen_ff[g] <= 3'h0;
            end else begin
               pin_ff     <= nxt_pin;
               sc_ff[g]   <= nxt_sc;
               seen_ff[g] <= nxt_seen;
            end
         end

         assign timer_output_pin[g] = pin_ff;
         assign timer_output_en[g]  = |sc_ff[g][OSB_HI:0];
         assign ev_set[3*g +: 3]    = set_f;
         assign sc_view[g]          = sc_ff[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Interrupt status and mask
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ev_ff  <= ZERO6;
         msk_ff <= ZERO6;
      end else begin
         ev_ff  <= (ev_ff & ~({6{wr_st}} & bus.wdata[5:0])) | ev_set;
         msk_ff <= wr_msk ? bus.wdata[5:0] : msk_ff;
      end
   end
   assign irq = |(ev_ff & msk_ff);

   ////////////////////////////////////////////////////////////////////
   // Read data, valid the cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      case (bus.addr)
         ADDR_CH0_SC:  rd_mux = sc_view[0];
         ADDR_CH1_SC:  rd_mux = sc_view[1];
         ADDR_IRQ_ST:  rd_mux = {2'h0, ev_ff};
         ADDR_IRQ_MSK: rd_mux = {2'h0, msk_ff};
         default:      rd_mux = ZERO8;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata_ff <= ZERO8;
      end else begin
         rdata_ff <= bus.rd ? rd_mux : ZERO8;
      end
   end
   assign rdata = rdata_ff;
endmodule
`default_nettype wire

/* testbench/tmcf_props.sv */
/* Checker of tmcf_top port behaviour.
   Assumes it is bound to every tmcf_top instance. */
`default_nettype none
module tmcf_props (
   input wire logic                       mclk,
   input wire logic                       sys_rst,
   input wire tmcf_pkg::tmcf_bus_type     bus,
   input wire logic [7:0]                 rdata,
   input wire tmcf_pkg::tmcf_chan_in_type ch0,
   input wire tmcf_pkg::tmcf_chan_in_type ch1,
   input wire logic [1:0]                 timer_output_pin,
   input wire logic [1:0]                 timer_output_en,
   input wire logic                       irq
);
   import tmcf_pkg::*;
   wire rd0 = bus.rd && bus.addr == ADDR_CH0_SC;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ////////////////
   en0_sel_a: assert property (bus.wr && bus.addr == ADDR_CH0_SC |=>
      timer_output_en[0] == (|$past(bus.wdata[3:0]))) else $error("en0");
   en1_sel_a: assert property (bus.wr && bus.addr == ADDR_CH1_SC |=>
      timer_output_en[1] == (|$past(bus.wdata[3:0]))) else $error("en1");
   rst_pin_a: assert property ($past(sys_rst) |->
      timer_output_pin == 2'h0) else $error("pin after reset");
   ch1_bit4_a: assert property (bus.rd && bus.addr == ADDR_CH1_SC |=>
      rdata[BIT_B4]) else $error("ch1 bit4");
   pin_hold_a: assert property (!ch0.tick |=>
      $stable(timer_output_pin[0])) else $error("pin moved");
   flag_a_a: assert property (ch0.tick && ch0.count == ch0.cmp_a
      ##1 !(ch0.xfer_a || bus.wr) ##1 rd0 |=> rdata[BIT_MFA])
      else $error("flag a");
   ovf_set_a: assert property (ch0.tick && ch0.count == CNT_MAX
      ##1 !bus.wr ##1 rd0 |=> rdata[BIT_OVF]) else $error("ovf");
   xfer_clr_a: assert property (ch0.xfer_a && !ch0.tick
      ##1 !ch0.tick ##1 rd0 |=> !rdata[BIT_MFA]) else $error("xfer a");
   rd_idle_a: assert property (!bus.rd |=> rdata == ZERO8)
      else $error("rdata idle");
   irq_mask_a: assert property (bus.wr && bus.addr == ADDR_IRQ_MSK &&
      bus.wdata == ZERO8 |=> !irq) else $error("irq masked");
   cover property (rd0 ##1 rdata[BIT_MFA]);
   cover property (ch0.tick && ch0.count == ch0.cmp_b);
   cover property (irq);
endmodule
bind tmcf_top tmcf_props tmcf_props_inst (.mclk, .sys_rst, .bus, .rdata,
   .ch0, .ch1, .timer_output_pin, .timer_output_en, .irq);
`default_nettype wire

/* testbench/timer8_compare_output_flags_bench.sv */
/* Bench of tmcf_top: registers, output pin, flags, interrupt.
   Assumes tmcf_props is bound to the design. */
`default_nettype none
module timer8_compare_output_flags_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import tmcf_pkg::*;
   logic mclk = 0, sys_rst = 1, irq;
   tmcf_bus_type bus = '0;
   tmcf_chan_in_type ch0 = '0, ch1 = '0;
   logic [7:0] rdata;
   logic [1:0] pin, en;
   int fails = 0, tests_run = 0;
   tmcf_top tmcf_top_inst (.mclk, .sys_rst, .bus, .rdata, .ch0, .ch1,
      .timer_output_pin(pin), .timer_output_en(en), .irq);
   ////////////////
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] d);
      @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk) bus.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [2:0] a, logic [7:0] e, string n);
      @(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk) bus.rd <= 1'b0;
      #1 chk(n, e, rdata);
   endtask
   task automatic tk(logic [7:0] c, logic t, logic xa, logic xb);
      @(posedge mclk) ch0 <= '{c, 8'h10, 8'h20, t, xa, xb};
      @(posedge mclk) ch0 <= '{c, 8'h10, 8'h20, 1'b0, 1'b0, 1'b0};
      #1;
   endtask
   task automatic tk1(logic [7:0] c);
      @(posedge mclk) ch1 <= '{c, 8'h10, 8'h20, 1'b1, 1'b0, 1'b0};
      @(posedge mclk) ch1 <= '{c, 8'h10, 8'h20, 1'b0, 1'b0, 1'b0};
      #1;
   endtask
   task automatic t_reset;
      rd(ADDR_CH0_SC, CH0_RST, "ch0");
      chk("pins", 8'h00, {4'h0, pin, en});
      wr(ADDR_CH1_SC, 8'h0F);
      rd(ADDR_CH1_SC, 8'h1F, "ch1");
      chk("en", 8'h02, {6'h0, en});
      wr(ADDR_CH1_SC, 8'h00);
      rd(3'h5, 8'h00, "unmapped");
      $display("t_reset done");
   endtask
   task automatic t_out;
      logic [7:0] os[10] = '{8'h01, 8'h02, 8'h02, 8'h03, 8'h03,
                             8'h04, 8'h08, 8'h08, 8'h0C, 8'h03};
      logic [7:0] cn[10] = '{8'h10, 8'h10, 8'h33, 8'h10, 8'h10,
                             8'h20, 8'h20, 8'h10, 8'h20, 8'h20};
      logic [9:0] ex = 10'h0D6;
      for (int i = 0; i < 10; i++) begin
         wr(ADDR_CH0_SC, os[i]);
         tk(cn[i], 1'b1, 1'b0, 1'b0);
         chk("pin", {7'h0, ex[i]}, {7'h0, pin[0]});
      end
      wr(ADDR_CH0_SC, 8'h02);
      tk(8'h10, 1'b0, 1'b0, 1'b0);
      chk("pin", 8'h00, {7'h0, pin[0]});
      rd(ADDR_CH0_SC, 8'hC2, "unarmed");
      $display("t_out done");
   endtask
   task automatic t_flags;
      tk(CNT_MAX, 1'b1, 1'b0, 1'b0);
      rd(ADDR_CH0_SC, 8'hE2, "ovf");
      wr(ADDR_CH0_SC, 8'hE2);
      rd(ADDR_CH0_SC, 8'hE2, "ones");
      wr(ADDR_CH0_SC, 8'h02);
      rd(ADDR_CH0_SC, 8'h02, "cleared");
      tk(8'h10, 1'b1, 1'b0, 1'b0);
      rd(ADDR_CH0_SC, 8'h42, "set a");
      fork
         wr(ADDR_CH0_SC, 8'h02);
         tk(8'h10, 1'b1, 1'b0, 1'b0);
      join
      rd(ADDR_CH0_SC, 8'h42, "set wins");
      $display("t_flags done");
   endtask
   task automatic t_xfer;
      tk(8'h20, 1'b1, 1'b0, 1'b0);
      tk(8'h00, 1'b0, 1'b1, 1'b0);
      rd(ADDR_CH0_SC, 8'h82, "xfer a");
      tk(8'h00, 1'b0, 1'b0, 1'b1);
      rd(ADDR_CH0_SC, 8'h02, "xfer b");
      $display("t_xfer done");
   endtask
   task automatic t_irq;
      wr(ADDR_IRQ_ST, 8'hFF);
      wr(ADDR_IRQ_MSK, 8'h01);
      chk("irq idle", 8'h00, {7'h0, irq});
      tk(CNT_MAX, 1'b1, 1'b0, 1'b0);
      chk("irq set", 8'h01, {7'h0, irq});
      rd(ADDR_IRQ_ST, 8'h01, "status");
      wr(ADDR_IRQ_MSK, 8'h00);
      chk("irq mask", 8'h00, {7'h0, irq});
      wr(ADDR_IRQ_MSK, 8'h01);
      wr(ADDR_IRQ_ST, 8'h01);
      chk("irq clr", 8'h00, {7'h0, irq});
      $display("t_irq done");
   endtask
   task automatic t_ch1;
      wr(ADDR_CH1_SC, 8'h07);
      tk1(8'h10);
      chk("pin1 a", 8'h01, {7'h0, pin[1]});
      tk1(8'h20);
      chk("pin1 b", 8'h00, {7'h0, pin[1]});
      tk1(CNT_MAX);
      rd(ADDR_CH1_SC, 8'hF7, "ch1 flags");
      wr(ADDR_CH1_SC, 8'h07);
      rd(ADDR_CH1_SC, 8'h17, "ch1 clr");
      rd(ADDR_IRQ_ST, 8'h38, "ch1 status");
      $display("t_ch1 done");
   endtask
   task automatic t_rerst;
      tk1(8'h10);
      chk("pin1 pre", 8'h01, {7'h0, pin[1]});
      @(posedge mclk) sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      #1 chk("pins rst", 8'h00, {4'h0, pin, en});
      rd(ADDR_CH1_SC, CH1_RST, "ch1 rst");
      rd(ADDR_IRQ_ST, 8'h00, "st rst");
      $display("t_rerst done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial forever #50 mclk = ~mclk;
   initial begin
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset;
      t_out;
      t_flags;
      t_xfer;
      t_irq;
      t_ch1;
      t_rerst;
      summarize;
   end
endmodule
`default_nettype wire
